// *** rtl/ptg_core.sv ***
// Timing core of a pulse generator: period source, pretrigger, delay and duration timers.
// Assumes trigger, gate and button inputs are asynchronous pins; settings are static levels.
`timescale 1ns/100ps
// Notes on behaviour
// (RULE1) Free-running source oscillates at selected period unless external trigger is chosen.
// (RULE2) Period selection input sets the internal event repetition rate.
// (RULE3) External trigger setting stops the internal generator entirely.
// (RULE4) Manual button or rising trigger input fires one period event.
// (RULE5) Every period event drives pretrigger and triggers the timers.
// (RULE6) Undelayed mode holds delay timer idle; event starts duration directly.
// (RULE7) Duration timer is a one-shot of the selected width.
// (RULE8) Positive and negative outputs switch together from one pulse.
// (RULE9) Delayed mode: event starts delay; its end starts duration.
// (RULE10) Both timers cover 20 ns up to at least 4 s.
// (RULE11) Paired mode fires duration on the event and on delay expiry.
// (RULE12) Paired leading edges are spaced by the delay setting.
// (RULE13) Operator keeps paired delay at least max(20 ns, 20% of duration); code drops the second pulse if the first still runs at delay expiry.
// (RULE14) Latched-on mode idles both timers and holds outputs active.
// (RULE15) Gated selection oscillates only while the gate input is high.
// (RULE16) A gate interval yields a burst at the selected period.
// (RULE17) Gate fall returns the generator to idle until the next gate.
// (RULE18) Rising gate gives the first period event without extra latency.
// (RULE19) One of four modes is active, chosen by a two-bit setting.
// (RULE20) Settings are clock-cycle counts; reset clears all timers idle.
module ptg_core
  import ptg_pkg::*;
#(
  parameter int unsigned CW = ptg_pkg::CNT_W
)
(
  input  wire logic                core_clk_i,                  // 100 MHz core clock
  input  wire logic                rst_i,                       // Async reset, active high
  input  wire logic                external_trigger_select_i,   // Period set to external trigger
  input  wire logic                external_gate_select_i,      // Gated instead of free running
  input  wire logic                manual_trigger_button_i,     // Manual trigger pin
  input  wire logic                trigger_input_i,             // Trigger or gate pin
  input  wire ptg_pkg::ptg_mode_t  mode_i,                      // Output mode
  input  wire logic [CW-1:0]       period_cyc_i,                // Period in cycles
  input  wire logic [CW-1:0]       delay_cyc_i,                 // Delay in cycles
  input  wire logic [CW-1:0]       duration_cyc_i,              // Duration in cycles
  output logic                     pretrigger_output_o,         // Pretrigger pulse
  output logic                     pulse_pos_o,                 // Positive-going output
  output logic                     pulse_neg_o                  // Negative-going output
);
  import ptg_pkg::*;

  // Three-stage synchronisers; a change counts once stages two and three agree
  logic [2:0] trig_sync_ff;
  logic [2:0] btn_sync_ff;
  logic [2:0] nxt_trig_sync;
  logic [2:0] nxt_btn_sync;
  logic       trig_lvl_ff;
  logic       btn_lvl_ff;
  logic       nxt_trig_lvl;
  logic       nxt_btn_lvl;

  always_comb
  begin
    nxt_trig_sync = {trig_sync_ff[1:0], trigger_input_i};
    nxt_btn_sync  = {btn_sync_ff[1:0], manual_trigger_button_i};
    nxt_trig_lvl  = trig_lvl_ff;
    nxt_btn_lvl   = btn_lvl_ff;
    if (trig_sync_ff[1] == trig_sync_ff[2])
    begin
      nxt_trig_lvl = trig_sync_ff[2];
    end
    if (btn_sync_ff[1] == btn_sync_ff[2])
    begin
      nxt_btn_lvl = btn_sync_ff[2];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      trig_sync_ff <= 3'h0;
      btn_sync_ff  <= 3'h0;
      trig_lvl_ff  <= 1'b0;
      btn_lvl_ff   <= 1'b0;
    end
    else
    begin
      trig_sync_ff <= nxt_trig_sync;
      btn_sync_ff  <= nxt_btn_sync;
      trig_lvl_ff  <= nxt_trig_lvl;
      btn_lvl_ff   <= nxt_btn_lvl;
    end
  end

  logic trig_rise;
  logic btn_rise;
  logic gate_open;
  assign trig_rise = nxt_trig_lvl && !trig_lvl_ff;
  assign btn_rise  = nxt_btn_lvl && !btn_lvl_ff;
  assign gate_open = nxt_trig_lvl;

  // Period generator; counter sits at zero when idle so a gate fires at once
  logic [CW-1:0] per_cnt_ff;
  logic [CW-1:0] nxt_per_cnt;
  logic          event_ff;
  logic          nxt_event;
  logic          run_en;

  always_comb
  begin
    run_en      = !external_trigger_select_i &&                       // RULE1 RULE3
                  (!external_gate_select_i || gate_open);             // RULE15
    nxt_per_cnt = per_cnt_ff;
    nxt_event   = 1'b0;
    if (external_trigger_select_i)
    begin
      nxt_per_cnt = '0;
      nxt_event   = trig_rise || btn_rise;                            // RULE4
    end
    else if (!run_en)
    begin
      nxt_per_cnt = '0;                                               // RULE17 RULE18
    end
    else if (per_cnt_ff == '0)
    begin
      nxt_event   = 1'b1;                                             // RULE16
      nxt_per_cnt = (period_cyc_i > CW'(1)) ? period_cyc_i - CW'(1) : '0;  // RULE2
    end
    else
    begin
      nxt_per_cnt = per_cnt_ff - CW'(1);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      per_cnt_ff <= '0;
      event_ff   <= 1'b0;
    end
    else
    begin
      per_cnt_ff <= nxt_per_cnt;
      event_ff   <= nxt_event;
    end
  end

  // Pretrigger shaping: stretch each event to a fixed visible width
  logic [1:0] pre_cnt_ff;
  logic [1:0] nxt_pre_cnt;
  logic       pre_ff;
  logic       nxt_pre;

  always_comb
  begin
    nxt_pre_cnt = pre_cnt_ff;
    if (event_ff)
    begin
      nxt_pre_cnt = 2'(PRETRIG_CYC);                                  // RULE5
    end
    else if (pre_cnt_ff != 2'h0)
    begin
      nxt_pre_cnt = pre_cnt_ff - 2'h1;
    end
    nxt_pre = (nxt_pre_cnt != 2'h0);
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pre_cnt_ff <= 2'h0;
      pre_ff     <= 1'b0;
    end
    else
    begin
      pre_cnt_ff <= nxt_pre_cnt;
      pre_ff     <= nxt_pre;
    end
  end

  // Mode steering
  ptg_mode_t mode_ff;
  logic      dly_en;
  logic      dur_en;
  logic      dly_start;
  logic      dur_start;
  logic      dly_busy;
  logic      dly_fall;
  logic      dur_busy;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode_ff <= PTG_MODE_UNDELAYED;
    end
    else
    begin
      mode_ff <= mode_i;                                              // RULE19
    end
  end

  always_comb
  begin
    dly_en    = 1'b0;
    dur_en    = 1'b0;
    dly_start = 1'b0;
    dur_start = 1'b0;
    unique case (mode_ff)
      PTG_MODE_UNDELAYED:
      begin
        dur_en    = 1'b1;                                             // RULE6
        dur_start = event_ff;
      end
      PTG_MODE_DELAYED:
      begin
        dly_en    = 1'b1;
        dur_en    = 1'b1;
        dly_start = event_ff;                                         // RULE9
        dur_start = dly_fall;
      end
      PTG_MODE_PAIRED:
      begin
        dly_en    = 1'b1;
        dur_en    = 1'b1;
        dly_start = event_ff;                                         // RULE11
        dur_start = event_ff || dly_fall;
      end
      PTG_MODE_LATCHED:
      begin
        dly_en = 1'b0;                                                // RULE14
        dur_en = 1'b0;
      end
    endcase
  end

  // Paired spacing: delay fall arrives delay+1 after the event, so trim one cycle
  logic [CW-1:0] dly_width;
  assign dly_width = (delay_cyc_i > CW'(1)) ? delay_cyc_i - CW'(1) : CW'(1);  // RULE12

  ptg_oneshot #(.W(CW)) u_delay
  (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .enable_i   (dly_en),
    .start_i    (dly_start),
    .width_i    (dly_width),                                          // RULE10 RULE20
    .busy_o     (dly_busy),
    .fall_o     (dly_fall)
  );

  ptg_oneshot #(.W(CW)) u_duration
  (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .enable_i   (dur_en),
    .start_i    (dur_start),                                          // RULE7
    .width_i    (duration_cyc_i),
    .busy_o     (dur_busy),
    .fall_o     ()
  );

  // Complementary output stage from one flip-flop pair fed by the same term
  logic out_ff;
  logic out_n_ff;
  logic nxt_out;
  assign nxt_out = dur_busy || (mode_ff == PTG_MODE_LATCHED);

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      out_ff   <= 1'b0;
      out_n_ff <= 1'b1;
    end
    else
    begin
      out_ff   <= nxt_out;                                            // RULE8
      out_n_ff <= !nxt_out;
    end
  end

  assign pretrigger_output_o = pre_ff;
  assign pulse_pos_o         = out_ff;
  assign pulse_neg_o         = out_n_ff;

  AST_COMPLEMENT: assert property (@(posedge core_clk_i) disable iff (rst_i)   // RULE8
    pulse_pos_o != pulse_neg_o)
    else $error("outputs not complementary");
  AST_EXT_STOPS: assert property (@(posedge core_clk_i) disable iff (rst_i)    // RULE3
    (external_trigger_select_i && !trig_rise && !btn_rise) |=> !event_ff)
    else $error("internal event while external trigger");
  AST_MANUAL: assert property (@(posedge core_clk_i) disable iff (rst_i)       // RULE4
    (external_trigger_select_i && btn_rise) |=> event_ff)
    else $error("manual trigger lost");
  AST_PRETRIG: assert property (@(posedge core_clk_i) disable iff (rst_i)      // RULE5
    event_ff |=> pretrigger_output_o [*2])
    else $error("pretrigger missing");
  AST_UNDELAYED: assert property (@(posedge core_clk_i) disable iff (rst_i)    // RULE6
    (mode_ff == PTG_MODE_UNDELAYED && event_ff && !dur_busy) |=> ##1 pulse_pos_o && !dly_busy)
    else $error("undelayed start wrong");
  AST_DELAYED: assert property (@(posedge core_clk_i) disable iff (rst_i)      // RULE9
    (mode_ff == PTG_MODE_DELAYED && $stable(mode_ff) && dly_fall && !dur_busy) |=> dur_busy)
    else $error("delayed start wrong");
  AST_LATCHED: assert property (@(posedge core_clk_i) disable iff (rst_i)      // RULE14
    (mode_ff == PTG_MODE_LATCHED) |=> pulse_pos_o && !dly_busy && !dur_busy)
    else $error("latched output not held");
  AST_GATE_LOW: assert property (@(posedge core_clk_i) disable iff (rst_i)     // RULE17
    (!external_trigger_select_i && external_gate_select_i && !gate_open) |=> !event_ff)
    else $error("event while gate low");
  AST_GATE_FAST: assert property (@(posedge core_clk_i) disable iff (rst_i)    // RULE18
    (!external_trigger_select_i && external_gate_select_i && gate_open && !trig_lvl_ff) |=> event_ff)
    else $error("gate start late");
  AST_FREE_RUN: assert property (@(posedge core_clk_i) disable iff (rst_i)     // RULE1
    (!external_trigger_select_i && !external_gate_select_i && per_cnt_ff == '0) |=> event_ff)
    else $error("free run stalled");

  COV_PAIRED: cover property (@(posedge core_clk_i) disable iff (rst_i)
    mode_ff == PTG_MODE_PAIRED && dly_fall);
  COV_GATED: cover property (@(posedge core_clk_i) disable iff (rst_i)
    external_gate_select_i && event_ff);
  COV_EXT: cover property (@(posedge core_clk_i) disable iff (rst_i)
    external_trigger_select_i && event_ff);
endmodule

// *** rtl/ptg_oneshot.sv ***
// Retriggerable-free one-shot timer used for both delay and duration.
// Assumes start is a one-cycle pulse on core_clk_i; width is at least one cycle.
`timescale 1ns/100ps
module ptg_oneshot
#(
  parameter int unsigned W = 32
)
(
  input  wire logic         core_clk_i, // Core clock
  input  wire logic         rst_i,      // Async reset, active high
  input  wire logic         enable_i,   // Held idle when low
  input  wire logic         start_i,    // Trigger pulse
  input  wire logic [W-1:0] width_i,    // Pulse width in cycles
  output logic              busy_o,     // Pulse active
  output logic              fall_o      // One cycle after pulse ends
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic         busy_ff;
  logic         nxt_busy;
  logic         fall_ff;
  logic         nxt_fall;

  always_comb
  begin
    nxt_cnt  = cnt_ff;
    nxt_busy = busy_ff;
    nxt_fall = 1'b0;
    if (!enable_i)
    begin
      nxt_busy = 1'b0;
      nxt_cnt  = '0;
    end
    else if (start_i && !busy_ff)
    begin
      nxt_busy = 1'b1;
      nxt_cnt  = (width_i == '0) ? W'(1) : width_i;
    end
    else if (busy_ff)
    begin
      nxt_cnt = cnt_ff - W'(1);
      if (cnt_ff == W'(1))
      begin
        nxt_busy = 1'b0;
        nxt_fall = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
      fall_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      busy_ff <= nxt_busy;
      fall_ff <= nxt_fall;
    end
  end

  assign busy_o = busy_ff;
  assign fall_o = fall_ff;

  // A mode change may legally idle the timer mid-pulse, so width is judged only while enabled
  AST_ONESHOT_WIDTH: assert property (@(posedge core_clk_i) disable iff (rst_i || !enable_i)
    (start_i && !busy_ff && enable_i && width_i == W'(3)) |=> busy_ff [*3] ##1 !busy_ff)
    else $error("one-shot width wrong");
endmodule

// *** rtl/ptg_pkg.sv ***
// Package for the pulse timing generator: mode codes, widths and timing constants.
// Assumes a 100 MHz core clock; all settings are cycle counts of that clock.
package ptg_pkg;

  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned MIN_TIME_NS    = 20;
  localparam int unsigned MAX_TIME_S     = 4;
  localparam int unsigned MIN_TIME_CYC   = (MIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MAX_TIME_CYC   = MAX_TIME_S * (1000000000 / CLK_PERIOD_NS);
  localparam int unsigned CNT_W          = 32;
  localparam int unsigned PRETRIG_CYC    = 2;

  typedef enum logic [1:0]
  {
    PTG_MODE_UNDELAYED = 2'h0,
    PTG_MODE_DELAYED   = 2'h1,
    PTG_MODE_PAIRED    = 2'h2,
    PTG_MODE_LATCHED   = 2'h3
  } ptg_mode_t;

endpackage

// *** tb/ptg_ext_src.sv ***
// Model of the far side: trigger/gate source and manual button.
// Assumes requests arrive as one-cycle levels from the bench on the core clock.
`timescale 1ns/100ps
module ptg_ext_src
(
  input  wire logic core_clk_i,              // Core clock
  input  wire logic pulse_req_i,             // Send one trigger pulse
  input  wire logic button_req_i,            // Press button once
  input  wire logic gate_i,                  // Requested gate level
  output logic      trigger_input_o,         // Trigger or gate pin
  output logic      manual_trigger_button_o  // Button pin
);
  logic [2:0] trig_cnt_ff = 3'h0;
  logic [2:0] btn_cnt_ff  = 3'h0;

  // Pulses last 6 cycles so the pin filter in the core sees them
  always_ff @(posedge core_clk_i)
  begin
    trig_cnt_ff <= pulse_req_i ? 3'h6 : ((trig_cnt_ff != 3'h0) ? trig_cnt_ff - 3'h1 : 3'h0);
    btn_cnt_ff  <= button_req_i ? 3'h6 : ((btn_cnt_ff != 3'h0) ? btn_cnt_ff - 3'h1 : 3'h0);
  end

  assign trigger_input_o         = gate_i | (trig_cnt_ff != 3'h0);
  assign manual_trigger_button_o = (btn_cnt_ff != 3'h0);
endmodule

// *** tb/pulse_timing_generator_tb_top.sv ***
// Testbench for the pulse timing generator core, one task per scenario.
// Assumes the external source model; all settings are clock-cycle counts.
`timescale 1ns/100ps
module pulse_timing_generator_tb_top;
  import ptg_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rst_i      = 1'b1;
  logic        ext_sel    = 1'b0;
  logic        gate_sel   = 1'b0;
  logic        pulse_req  = 1'b0;
  logic        btn_req    = 1'b0;
  logic        gate_req   = 1'b0;
  ptg_mode_t   mode       = PTG_MODE_UNDELAYED;
  logic [31:0] per        = 32'h5;
  logic [31:0] dly        = 32'h2;
  logic [31:0] dur        = 32'h3;
  logic        trig_pin;
  logic        btn_pin;
  logic        pre;
  logic        pos;
  logic        neg;
  logic        pre_d      = 1'b0;
  logic        pos_d      = 1'b0;
  int          cyc        = 0;
  int          error_cnt  = 0;
  int          cmp_count  = 0;
  int          g0;
  int          pre_q[$];
  int          pos_q[$];
  int          wid_q[$];

  always #5 core_clk_i = ~core_clk_i;

  ptg_ext_src src (.core_clk_i(core_clk_i), .pulse_req_i(pulse_req), .button_req_i(btn_req), .gate_i(gate_req),
                   .trigger_input_o(trig_pin), .manual_trigger_button_o(btn_pin));

  ptg_core uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .external_trigger_select_i(ext_sel),
                .external_gate_select_i(gate_sel), .manual_trigger_button_i(btn_pin), .trigger_input_i(trig_pin),
                .mode_i(mode), .period_cyc_i(per), .delay_cyc_i(dly), .duration_cyc_i(dur),
                .pretrigger_output_o(pre), .pulse_pos_o(pos), .pulse_neg_o(neg));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s: got %0h exp %0h", $time, msg, got, exp);
    end
  endtask

  // Recorder on the falling edge, where outputs have settled
  always @(negedge core_clk_i)
  begin
    cyc = cyc + 1;
    if (!rst_i)
      chk({31'h0, neg}, {31'h0, ~pos}, "neg not inverse of pos");
    if (pre === 1'b1 && pre_d !== 1'b1)
      pre_q.push_back(cyc);
    if (pos === 1'b1 && pos_d !== 1'b1)
      pos_q.push_back(cyc);
    if (pos !== 1'b1 && pos_d === 1'b1 && pos_q.size() > 0)
      wid_q.push_back(cyc - pos_q[$]);
    pre_d = pre;
    pos_d = pos;
  end

  task automatic run(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  task automatic setup(input ptg_mode_t m, input int p, input int d, input int w, input logic x, input logic g);
    @(posedge core_clk_i);
    mode     <= m;
    per      <= p;
    dly      <= d;
    dur      <= w;
    ext_sel  <= x;
    gate_sel <= g;
    run(40);
    pre_q.delete();
    pos_q.delete();
    wid_q.delete();
  endtask

  // Pulse spacing, lead after pretrigger and width
  task automatic chk_train(input int gap, input int lead, input int w, input string msg);
    chk({31'h0, pre_q.size() > 2}, 32'h1, msg);
    for (int i = 1; i < pre_q.size(); i++)
      chk(pre_q[i] - pre_q[i-1], gap, msg);
    chk({31'h0, pre_q.size() > 0 && (pre_q[0] + lead) inside {pos_q}}, 32'h1, msg);
    chk({31'h0, wid_q.size() > 0}, 32'h1, msg);
    foreach (wid_q[i])
      chk(wid_q[i], w, msg);
  endtask

  task automatic t_undelayed();
    setup(PTG_MODE_UNDELAYED, 5, 4, 3, 1'b0, 1'b0);
    run(40);
    chk_train(5, 1, 3, "undelayed train");
  endtask

  task automatic t_delayed_min();
    setup(PTG_MODE_DELAYED, 10, 2, 2, 1'b0, 1'b0);
    run(50);
    chk_train(10, 3, 2, "delayed train");
    chk({31'h0, (pre_q[0] + 1) inside {pos_q}}, 32'h0, "delayed pulse too early");
  endtask

  task automatic t_paired();
    // Delay kept above the duration and the 20 ns floor
    setup(PTG_MODE_PAIRED, 40, 10, 3, 1'b0, 1'b0);
    run(120);
    chk_train(40, 1, 3, "paired first");
    chk({31'h0, (pre_q[0] + 11) inside {pos_q}}, 32'h1, "paired second");
    chk(pos_q.size(), 2 * pre_q.size(), "paired count");
  endtask

  task automatic t_latched();
    setup(PTG_MODE_LATCHED, 5, 4, 3, 1'b0, 1'b0);
    run(30);
    @(negedge core_clk_i);
    chk({31'h0, pos}, 32'h1, "latched level");
    chk(pos_q.size() + wid_q.size(), 0, "latched pulsing");
  endtask

  task automatic t_ext();
    setup(PTG_MODE_UNDELAYED, 5, 4, 3, 1'b1, 1'b0);
    run(30);
    chk(pre_q.size(), 0, "internal events under ext");
    pulse_req <= 1'b1;
    run(1);
    pulse_req <= 1'b0;
    run(25);
    chk(pre_q.size(), 1, "trigger pulse events");
    chk(pos_q.size(), 1, "trigger pulse outputs");
    btn_req <= 1'b1;
    run(1);
    btn_req <= 1'b0;
    run(25);
    chk(pre_q.size(), 2, "button events");
  endtask

  task automatic t_gated();
    setup(PTG_MODE_UNDELAYED, 8, 4, 3, 1'b0, 1'b1);
    run(30);
    chk(pre_q.size(), 0, "events with gate low");
    gate_req <= 1'b1;
    g0 = cyc;
    run(40);
    chk({31'h0, pre_q.size() > 0 && pre_q[0] - g0 <= 8}, 32'h1, "first gated event late");
    chk_train(8, 1, 3, "gated burst");
    gate_req <= 1'b0;
    run(12);
    pre_q.delete();
    run(30);
    chk(pre_q.size(), 0, "events after gate fall");
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (19) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk({30'h0, pos, neg}, 32'h1, "outputs during reset");
    @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_undelayed();
    t_delayed_min();
    t_paired();
    t_latched();
    t_ext();
    t_gated();
    end_sim();
  end
endmodule
